/* File: hdl/fsi_pkg.sv */
// Purpose: Constants and carriers for the framer status, mask and counter bank.
// Assumes: Registers sit at word index times four on an AXI4-Lite bus.
// Notes: Timer figures are in milliseconds; cycle counts derive from them.
package fsi_pkg;

	localparam logic [7:0] IDX_STATUS_ONE = 8'h20;
	localparam logic [7:0] IDX_STATUS_TWO = 8'h21;
	localparam logic [7:0] IDX_CV_HIGH = 8'h23;
	localparam logic [7:0] IDX_CV_LOW = 8'h24;
	localparam logic [7:0] IDX_PATH_HIGH = 8'h28;
	localparam logic [7:0] IDX_PATH_LOW = 8'h29;
	localparam logic [7:0] IDX_MOS_HIGH = 8'h2a;
	localparam logic [7:0] IDX_MOS_LOW = 8'h2b;
	localparam logic [7:0] IDX_CONTROL = 8'h30;
	localparam logic [7:0] IDX_MATCH_A = 8'h31;
	localparam logic [7:0] IDX_MATCH_B = 8'h32;
	localparam logic [7:0] IDX_ENABLE_TWO = 8'h6f;
	localparam logic [7:0] IDX_ENABLE_ONE = 8'h7f;

	// Event status two bit positions.
	localparam int ST2_RX_MF = 7;
	localparam int ST2_TX_MF = 6;
	localparam int ST2_SEC = 5;
	localparam int ST2_DL_FULL = 4;
	localparam int ST2_DL_EMPTY = 3;
	localparam int ST2_MATCH = 2;
	localparam int ST2_ABORT = 1;
	localparam int ST2_SIG = 0;

	// Control register bit positions.
	localparam int CTL_INTERVAL = 0;
	localparam int CTL_ZSUB = 1;
	localparam int CTL_EXZ = 2;

	localparam logic [7:0] ENABLE_ONE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_TWO_RESET = 8'h00;
	localparam logic [2:0] CONTROL_RESET = 3'h0;

	localparam int SEC_SHORT_MS = 999;
	localparam int SEC_LONG_MS = 1002;
	localparam int INTERVAL_MS = 42;
	localparam int BLUE_WINDOW_MS = 3;
	localparam int BLUE_MAX_ZEROS = 5;
	localparam int ZERO_RUN_PLAIN = 16;
	localparam int ZERO_RUN_SUBST = 8;
	localparam int DL_ABORT_ONES = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic loop_up;
		logic loop_down;
		logic tx_clock_loss;
		logic slip;
		logic yellow;
		logic carrier_loss;
		logic sync_loss;
	} fsi_alarm_type;

	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} fsi_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fsi_axi_rsp_type;

endpackage

/* File: hdl/fsi_status_bank.sv */
// Purpose: Status flags, interrupt masks and error counters of one framer.
// Assumes: Event inputs come from framer logic on sys_clk_i; the receive
//          line clock is a pin and is synchronised before use.
// Notes: Registers are byte wide in the low bits of each 32-bit word.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module fsi_status_bank #(
	parameter int BITS_PER_MS = 1544,
	parameter int SIG_W = 24
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Register bus.
	input wire fsi_pkg::fsi_axi_req_type axi_i,
	output fsi_pkg::fsi_axi_rsp_type axi_o,
	// Receive line clock pin.
	input wire logic rx_line_clk_i,
	// Receive line events; rx_bit_zero_i is qualified by rx_bit_valid_i, bpv_pulse_i is not.
	input wire logic rx_bit_valid_i,
	input wire logic rx_bit_zero_i,
	input wire logic bpv_pulse_i,
	input wire logic subst_word_i,
	// Framing error events.
	input wire logic path_error_i,
	input wire logic mf_out_of_sync_i,
	// Facility data link.
	input wire logic dl_bit_valid_i,
	input wire logic dl_bit_i,
	input wire logic tx_datalink_empty_i,
	// Multiframe and signalling.
	input wire logic rx_multiframe_i,
	input wire logic tx_multiframe_i,
	input wire logic sig_valid_i,
	input wire logic [SIG_W-1:0] sig_bits_i,
	// Line alarms.
	input wire fsi_pkg::fsi_alarm_type alarm_i,
	// Interrupt.
	output logic irq_o
);

	if (BITS_PER_MS < 2 || BITS_PER_MS > 65535 || SIG_W < 1) begin : g_bad
		$error("fsi_status_bank: unsupported parameter values.");
	end

	localparam logic [15:0] MS_BITS = 16'(BITS_PER_MS - 1);
	localparam logic [10:0] SEC_SHORT = 11'(fsi_pkg::SEC_SHORT_MS - 1);
	localparam logic [10:0] SEC_LONG = 11'(fsi_pkg::SEC_LONG_MS - 1);
	localparam logic [5:0] INTERVAL = 6'(fsi_pkg::INTERVAL_MS - 1);
	localparam logic [1:0] BLUE_WIN = 2'(fsi_pkg::BLUE_WINDOW_MS - 1);
	localparam logic [7:0] BLUE_MAX = 8'(fsi_pkg::BLUE_MAX_ZEROS);
	localparam logic [4:0] RUN_PLAIN = 5'(fsi_pkg::ZERO_RUN_PLAIN);
	localparam logic [4:0] RUN_SUBST = 5'(fsi_pkg::ZERO_RUN_SUBST);
	localparam logic [3:0] ABORT_ONES = 4'(fsi_pkg::DL_ABORT_ONES);
	localparam logic [15:0] MAX16 = 16'hffff;
	localparam logic [15:0] MAX12 = 16'h0fff;

	typedef struct packed {
		logic clk_s1;
		logic clk_s2;
		logic clk_prev;
		logic [15:0] bit_cnt;
		logic [10:0] ms_cnt;
		logic [1:0] sec_phase;
		logic [5:0] int_cnt;
		logic [1:0] blue_ms;
		logic [7:0] blue_zeros;
		logic blue;
		logic [4:0] zero_run;
		logic [15:0] cv_live;
		logic [15:0] cv_snap;
		logic [11:0] path_live;
		logic [11:0] path_snap;
		logic [11:0] mos_live;
		logic [11:0] mos_snap;
		logic [7:0] dl_shift;
		logic [2:0] dl_count;
		logic [3:0] dl_ones;
		logic sig_seen;
		logic [SIG_W-1:0] sig_prev;
		logic [7:0] status_one;
		logic [7:0] status_two;
		logic [7:0] en_one;
		logic [7:0] en_two;
		logic [2:0] ctrl;
		logic [7:0] match_a;
		logic [7:0] match_b;
		logic aw_have;
		logic [11:0] awaddr;
		logic w_have;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
	} fsi_state_type;

	fsi_state_type s_q;
	fsi_state_type s_d;

	// Adds up to two events, stopping at the counter's ceiling.
	function automatic logic [15:0] sat_add(input logic [15:0] v,
			input logic [15:0] max, input logic [1:0] inc);
		logic [16:0] sum;
		sum = {1'b0, v} + {15'h0000, inc};
		if (sum > {1'b0, max}) begin
			return max;
		end
		return sum[15:0];
	endfunction

	// Decodes a byte address into a word index; upper bits must be clear.
	function automatic logic [8:0] word_index(input logic [11:0] addr);
		return {addr[11:10] != 2'h0, addr[9:2]};
	endfunction

	function automatic logic is_mapped(input logic [8:0] idx);
		if (idx[8]) begin
			return 1'b0;
		end
		unique case (idx[7:0])
			fsi_pkg::IDX_STATUS_ONE, fsi_pkg::IDX_STATUS_TWO,
			fsi_pkg::IDX_CV_HIGH, fsi_pkg::IDX_CV_LOW,
			fsi_pkg::IDX_PATH_HIGH, fsi_pkg::IDX_PATH_LOW,
			fsi_pkg::IDX_MOS_HIGH, fsi_pkg::IDX_MOS_LOW,
			fsi_pkg::IDX_CONTROL, fsi_pkg::IDX_MATCH_A,
			fsi_pkg::IDX_MATCH_B, fsi_pkg::IDX_ENABLE_TWO,
			fsi_pkg::IDX_ENABLE_ONE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	always_comb begin
		logic bit_tick;
		logic ms_tick;
		logic sec_tick;
		logic int_tick;
		logic upd;
		logic [1:0] cv_inc;
		logic [4:0] run_limit;
		logic [7:0] dl_byte;
		logic [7:0] st1_set;
		logic [7:0] st2_set;
		logic [8:0] ridx;
		logic [8:0] widx;
		logic [7:0] rbyte;
		logic rd_st1;
		logic rd_st2;
		bit_tick = 1'b0;
		ms_tick = 1'b0;
		sec_tick = 1'b0;
		int_tick = 1'b0;
		upd = 1'b0;
		cv_inc = 2'h0;
		run_limit = RUN_PLAIN;
		dl_byte = 8'h00;
		st1_set = 8'h00;
		st2_set = 8'h00;
		ridx = word_index(axi_i.araddr);
		widx = word_index(s_q.awaddr);
		rbyte = 8'h00;
		rd_st1 = 1'b0;
		rd_st2 = 1'b0;
		s_d = s_q;

		// Line clock timing: only the second stage feeds the edge detector.
		s_d.clk_s1 = rx_line_clk_i;
		s_d.clk_s2 = s_q.clk_s1;
		s_d.clk_prev = s_q.clk_s2;
		bit_tick = s_q.clk_s2 && !s_q.clk_prev;
		if (bit_tick) begin
			if (s_q.bit_cnt == MS_BITS) begin
				s_d.bit_cnt = 16'h0000;
				ms_tick = 1'b1;
			end else begin
				s_d.bit_cnt = s_q.bit_cnt + 16'h0001;
			end
		end
		if (ms_tick) begin
			if (s_q.ms_cnt == ((s_q.sec_phase == 2'h2) ? SEC_LONG
					: SEC_SHORT)) begin
				s_d.ms_cnt = 11'h000;
				sec_tick = 1'b1;
				s_d.sec_phase = (s_q.sec_phase == 2'h2) ? 2'h0
					: s_q.sec_phase + 2'h1;
			end else begin
				s_d.ms_cnt = s_q.ms_cnt + 11'h001;
			end
			if (s_q.int_cnt == INTERVAL) begin
				s_d.int_cnt = 6'h00;
				int_tick = 1'b1;
			end else begin
				s_d.int_cnt = s_q.int_cnt + 6'h01;
			end
		end
		upd = s_q.ctrl[fsi_pkg::CTL_INTERVAL] ? int_tick : sec_tick;

		// Blue alarm: unframed ones leave at most a few zeros per window,
		// while framing bits of a framed ones signal give many more.
		if (rx_bit_valid_i && rx_bit_zero_i && s_q.blue_zeros != 8'hff) begin
			s_d.blue_zeros = s_q.blue_zeros + 8'h01;
		end
		if (ms_tick) begin
			if (s_q.blue_ms == BLUE_WIN) begin
				s_d.blue_ms = 2'h0;
				s_d.blue = (s_d.blue_zeros <= BLUE_MAX);
				s_d.blue_zeros = 8'h00;
			end else begin
				s_d.blue_ms = s_q.blue_ms + 2'h1;
			end
		end

		// Code violations count regardless of sync state.
		run_limit = s_q.ctrl[fsi_pkg::CTL_ZSUB] ? RUN_SUBST : RUN_PLAIN;
		if (bpv_pulse_i && !(s_q.ctrl[fsi_pkg::CTL_ZSUB] && subst_word_i)) begin
			cv_inc = cv_inc + 2'h1;
		end
		if (rx_bit_valid_i) begin
			if (!rx_bit_zero_i || !s_q.ctrl[fsi_pkg::CTL_EXZ]) begin
				s_d.zero_run = 5'h00;
			end else if (s_q.zero_run + 5'h01 == run_limit) begin
				s_d.zero_run = 5'h00;
				cv_inc = cv_inc + 2'h1;
			end else begin
				s_d.zero_run = s_q.zero_run + 5'h01;
			end
		end

		// Snapshot on the interval or one-second boundary, as CTL_INTERVAL selects; the live count restarts
		// with this cycle's events so none are lost.
		if (upd) begin
			s_d.cv_snap = s_q.cv_live;
			s_d.path_snap = s_q.path_live;
			s_d.mos_snap = s_q.mos_live;
			s_d.cv_live = {14'h0000, cv_inc};
			s_d.path_live = {11'h000, path_error_i && !alarm_i.sync_loss};
			s_d.mos_live = {11'h000, mf_out_of_sync_i};
		end else begin
			s_d.cv_live = sat_add(s_q.cv_live, MAX16, cv_inc);
			s_d.path_live = 12'(sat_add({4'h0, s_q.path_live}, MAX12,
				{1'b0, path_error_i && !alarm_i.sync_loss}));
			s_d.mos_live = 12'(sat_add({4'h0, s_q.mos_live}, MAX12,
				{1'b0, mf_out_of_sync_i}));
		end

		// Facility data link receive byte assembly.
		if (dl_bit_valid_i) begin
			dl_byte = {s_q.dl_shift[6:0], dl_bit_i};
			s_d.dl_shift = dl_byte;
			s_d.dl_count = s_q.dl_count + 3'h1;
			if (s_q.dl_count == 3'h7) begin
				st2_set[fsi_pkg::ST2_DL_FULL] = 1'b1;
				if (dl_byte == s_q.match_a || dl_byte == s_q.match_b) begin
					st2_set[fsi_pkg::ST2_MATCH] = 1'b1;
				end
			end
			if (!dl_bit_i) begin
				s_d.dl_ones = 4'h0;
			end else if (s_q.dl_ones + 4'h1 == ABORT_ONES) begin
				s_d.dl_ones = 4'h0;
				st2_set[fsi_pkg::ST2_ABORT] = 1'b1;
			end else begin
				s_d.dl_ones = s_q.dl_ones + 4'h1;
			end
		end

		// The first valid sample only primes the reference.
		if (sig_valid_i) begin
			s_d.sig_seen = 1'b1;
			s_d.sig_prev = sig_bits_i;
			if (s_q.sig_seen && sig_bits_i != s_q.sig_prev) begin
				st2_set[fsi_pkg::ST2_SIG] = 1'b1;
			end
		end
		st2_set[fsi_pkg::ST2_RX_MF] = rx_multiframe_i;
		st2_set[fsi_pkg::ST2_TX_MF] = tx_multiframe_i;
		st2_set[fsi_pkg::ST2_SEC] = sec_tick;
		st2_set[fsi_pkg::ST2_DL_EMPTY] = tx_datalink_empty_i;
		st1_set = {alarm_i.loop_up, alarm_i.loop_down,
			alarm_i.tx_clock_loss, alarm_i.slip, s_q.blue,
			alarm_i.yellow, alarm_i.carrier_loss,
			alarm_i.sync_loss};

		// Write channel: address and data may arrive in either order.
		if (axi_i.awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr = axi_i.awaddr;
		end
		if (axi_i.wvalid && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.wdata = axi_i.wdata[7:0];
			s_d.wstrb0 = axi_i.wstrb[0];
		end
		if (s_q.bvalid && axi_i.bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = is_mapped(widx) ? fsi_pkg::RESP_OKAY
				: fsi_pkg::RESP_SLVERR;
			if (s_q.wstrb0 && !widx[8]) begin
				unique case (widx[7:0])
					fsi_pkg::IDX_ENABLE_ONE: s_d.en_one = s_q.wdata;
					fsi_pkg::IDX_ENABLE_TWO: s_d.en_two = s_q.wdata;
					fsi_pkg::IDX_CONTROL: s_d.ctrl = s_q.wdata[2:0];
					fsi_pkg::IDX_MATCH_A: s_d.match_a = s_q.wdata;
					fsi_pkg::IDX_MATCH_B: s_d.match_b = s_q.wdata;
					default: s_d.ctrl = s_q.ctrl;
				endcase
			end
		end
		s_d.awready = !s_d.aw_have;
		s_d.wready = !s_d.w_have;

		// Read channel: one read at a time, answered the next cycle.
		if (s_q.rvalid && axi_i.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_i.arvalid && s_q.arready) begin
			if (!ridx[8]) begin
				unique case (ridx[7:0])
					fsi_pkg::IDX_STATUS_ONE: begin
						rbyte = s_q.status_one;
						rd_st1 = 1'b1;
					end
					fsi_pkg::IDX_STATUS_TWO: begin
						rbyte = s_q.status_two;
						rd_st2 = 1'b1;
					end
					fsi_pkg::IDX_CV_HIGH: rbyte = s_q.cv_snap[15:8];
					fsi_pkg::IDX_CV_LOW: rbyte = s_q.cv_snap[7:0];
					fsi_pkg::IDX_PATH_HIGH: rbyte = {4'h0, s_q.path_snap[11:8]};
					fsi_pkg::IDX_PATH_LOW: rbyte = s_q.path_snap[7:0];
					fsi_pkg::IDX_MOS_HIGH: rbyte = {4'h0, s_q.mos_snap[11:8]};
					fsi_pkg::IDX_MOS_LOW: rbyte = s_q.mos_snap[7:0];
					fsi_pkg::IDX_CONTROL: rbyte = {5'h00, s_q.ctrl};
					fsi_pkg::IDX_MATCH_A: rbyte = s_q.match_a;
					fsi_pkg::IDX_MATCH_B: rbyte = s_q.match_b;
					fsi_pkg::IDX_ENABLE_TWO: rbyte = s_q.en_two;
					fsi_pkg::IDX_ENABLE_ONE: rbyte = s_q.en_one;
					default: rbyte = 8'h00;
				endcase
			end
			s_d.rvalid = 1'b1;
			s_d.rdata = {24'h000000, rbyte};
			s_d.rresp = is_mapped(ridx) ? fsi_pkg::RESP_OKAY
				: fsi_pkg::RESP_SLVERR;
		end
		s_d.arready = !s_d.rvalid;

		// Flags clear on read, but a new event in the same cycle wins.
		s_d.status_one = (rd_st1 ? 8'h00 : s_q.status_one) | st1_set;
		s_d.status_two = (rd_st2 ? 8'h00 : s_q.status_two) | st2_set;
		s_d.irq = |((s_d.status_one & s_d.en_one)
			| (s_d.status_two & s_d.en_two));
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
			s_q.en_one <= fsi_pkg::ENABLE_ONE_RESET;
			s_q.en_two <= fsi_pkg::ENABLE_TWO_RESET;
			s_q.ctrl <= fsi_pkg::CONTROL_RESET;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign axi_o.awready = s_q.awready;
	assign axi_o.wready = s_q.wready;
	assign axi_o.bvalid = s_q.bvalid;
	assign axi_o.bresp = s_q.bresp;
	assign axi_o.arready = s_q.arready;
	assign axi_o.rvalid = s_q.rvalid;
	assign axi_o.rdata = s_q.rdata;
	assign axi_o.rresp = s_q.rresp;
	assign irq_o = s_q.irq;

endmodule // fsi_status_bank

/* File: testbench/fsi_host_model.sv */
// Purpose: Host processor model issuing single AXI4-Lite transfers.
// Assumes: One transfer at a time; signals change just after a rising edge.
// Notes: A transfer that never answers ends the run through the bench.
`timescale 1ns/1ps
module fsi_host_model (
	// Clock.
	input wire logic sys_clk_i,
	// Register bus.
	input wire fsi_pkg::fsi_axi_rsp_type axi_i,
	output fsi_pkg::fsi_axi_req_type axi_o
);
	initial axi_o = '0;
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic [1:0] r);
		int n;
		n = 0;
		q = '0;
		r = '0;
		@(posedge sys_clk_i);
		if (w) begin
			axi_o.awvalid <= 1'b1;
			axi_o.awaddr <= a;
			axi_o.wvalid <= 1'b1;
			axi_o.wdata <= {24'h0, d};
			axi_o.wstrb <= 4'hf;
			axi_o.bready <= 1'b1;
		end else begin
			axi_o.arvalid <= 1'b1;
			axi_o.araddr <= a;
			axi_o.rready <= 1'b1;
		end
		forever begin
			@(posedge sys_clk_i);
			if (axi_o.awvalid && axi_i.awready) axi_o.awvalid <= 1'b0;
			if (axi_o.wvalid && axi_i.wready) axi_o.wvalid <= 1'b0;
			if (axi_o.arvalid && axi_i.arready) axi_o.arvalid <= 1'b0;
			if (axi_o.bready && axi_i.bvalid) begin
				axi_o.bready <= 1'b0;
				r = axi_i.bresp;
				return;
			end
			if (axi_o.rready && axi_i.rvalid) begin
				axi_o.rready <= 1'b0;
				q = axi_i.rdata;
				r = axi_i.rresp;
				return;
			end
			n++;
			if (n > 1000) tb.hang();
		end
	endtask
endmodule // fsi_host_model

/* File: testbench/fsi_status_bank_props.sv */
// Purpose: Bus, mask and interrupt checks on the status bank ports.
// Assumes: One clock domain; masks are tracked from completed writes.
// Notes: Tracked masks follow the bank's own write timing edge for edge.
`timescale 1ns/1ps
module fsi_status_bank_props (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Watched ports.
	input wire fsi_pkg::fsi_axi_req_type axi_i,
	input wire fsi_pkg::fsi_axi_rsp_type axi_o,
	input wire fsi_pkg::fsi_alarm_type alarm_i,
	input wire logic irq_o
);
	logic [11:0] wa_q;
	logic [8:0] wd_q;
	logic ah_q;
	logic wh_q;
	logic [7:0] en1_q;
	logic [7:0] en2_q;
	logic [7:0] al;
	assign al = {alarm_i[6:3], 1'b0, alarm_i[2:0]};
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wa_q <= '0;
			wd_q <= '0;
			ah_q <= 1'b0;
			wh_q <= 1'b0;
			en1_q <= '0;
			en2_q <= '0;
		end else begin
			if (axi_i.awvalid && axi_o.awready) begin
				wa_q <= axi_i.awaddr;
				ah_q <= 1'b1;
			end
			if (axi_i.wvalid && axi_o.wready) begin
				wd_q <= {axi_i.wstrb[0], axi_i.wdata[7:0]};
				wh_q <= 1'b1;
			end
			// A lagging mask copy would let the quiet check fire while a
			// new mask already drives the interrupt, so mirror the edge.
			if (ah_q && wh_q && !axi_o.bvalid) begin
				ah_q <= 1'b0;
				wh_q <= 1'b0;
				if (wd_q[8] && wa_q[11:2] ==
						{2'h0, fsi_pkg::IDX_ENABLE_ONE}) begin
					en1_q <= wd_q[7:0];
				end
				if (wd_q[8] && wa_q[11:2] ==
						{2'h0, fsi_pkg::IDX_ENABLE_TWO}) begin
					en2_q <= wd_q[7:0];
				end
			end
		end
	end
	a_alarm_irq: assert property (|($past(al) & en1_q) |-> irq_o)
		else $error("Enabled alarm gave no interrupt.");
	a_irq_quiet: assert property (en1_q == 0 && en2_q == 0 |-> !irq_o)
		else $error("Interrupt with all masks clear.");
	a_rd_answer: assert property (
		axi_i.arvalid && axi_o.arready |=> axi_o.rvalid && !axi_o.arready)
		else $error("Read answer late.");
	a_rd_hold: assert property (
		axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid && $stable(axi_o.rdata))
		else $error("Read data dropped.");
	a_wr_answer: assert property (axi_i.awvalid && axi_o.awready
		&& axi_i.wvalid && axi_o.wready |=> !axi_o.bvalid ##1 axi_o.bvalid)
		else $error("Write answer timing wrong.");
	a_wr_hold: assert property (
		axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp))
		else $error("Write answer dropped.");
	a_bad_addr: assert property (axi_i.arvalid && axi_o.arready
		&& axi_i.araddr[11:10] != 2'h0 |=> axi_o.rresp == fsi_pkg::RESP_SLVERR
		&& axi_o.rdata == 32'h0)
		else $error("Outside address not refused.");
	a_aw_busy: assert property (
		axi_i.awvalid && axi_o.awready |=> !axi_o.awready)
		else $error("Second write address taken.");
	c_read: cover property (axi_o.rvalid && axi_i.rready);
	c_write: cover property (axi_o.bvalid && axi_i.bready);
	c_irq: cover property ($rose(irq_o));
endmodule // fsi_status_bank_props
bind fsi_status_bank fsi_status_bank_props props_i (.sys_clk_i(sys_clk_i),
	.arst_n_i(arst_n_i), .axi_i(axi_i), .axi_o(axi_o), .alarm_i(alarm_i),
	.irq_o(irq_o));

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the status, mask and counter bank.
// Assumes: Two rising line clock edges make a millisecond; line period is 20 ns.
// Notes: Counter checks lock onto a snapshot before injecting errors.
`timescale 1ns/1ps
module tb;
	localparam int TICK_MS = 8;
	logic clk;
	logic rst_n = 1'b0;
	logic rlc = 1'b0;
	logic rbv = 1'b0;
	logic rbz = 1'b0;
	logic bpv = 1'b0;
	logic sub = 1'b0;
	logic pe = 1'b0;
	logic mos = 1'b0;
	logic dlv = 1'b0;
	logic dlb = 1'b0;
	logic txe = 1'b0;
	logic mf = 1'b0;
	logic sigv = 1'b0;
	logic [23:0] sigb = 24'h0;
	fsi_pkg::fsi_alarm_type al = '0;
	fsi_pkg::fsi_axi_req_type req;
	fsi_pkg::fsi_axi_rsp_type rsp;
	logic irq;
	logic [31:0] rdv;
	logic [1:0] rr;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int t[4];
	int n;
	logic [7:0] cctl[2] = '{8'h07, 8'h05};
	int cb[2] = '{5, 2};
	int cs[2] = '{3, 0};
	int cz[2] = '{8, 24};
	int ce[2] = '{6, 3};
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always #10 rlc = ~rlc;
	always @(posedge clk) cyc <= cyc + 1;
	fsi_status_bank #(.BITS_PER_MS(2), .SIG_W(24)) fsi_status_bank_i (
		.sys_clk_i(clk), .arst_n_i(rst_n), .axi_i(req), .axi_o(rsp),
		.rx_line_clk_i(rlc), .rx_bit_valid_i(rbv), .rx_bit_zero_i(rbz),
		.bpv_pulse_i(bpv), .subst_word_i(sub), .path_error_i(pe),
		.mf_out_of_sync_i(mos), .dl_bit_valid_i(dlv), .dl_bit_i(dlb),
		.tx_datalink_empty_i(txe), .rx_multiframe_i(mf),
		.tx_multiframe_i(mf), .sig_valid_i(sigv), .sig_bits_i(sigb),
		.alarm_i(al), .irq_o(irq));
	fsi_host_model fsi_host_model_i (.sys_clk_i(clk), .axi_i(rsp),
		.axi_o(req));
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		give_verdict();
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		fsi_host_model_i.xfer(1'b1, {2'h0, i, 2'h0}, d, rdv, rr);
	endtask
	task automatic rd(input logic [7:0] i);
		fsi_host_model_i.xfer(1'b0, {2'h0, i, 2'h0}, 8'h0, rdv, rr);
	endtask
	task automatic bits(input int k, input logic z);
		repeat (k) begin
			@(posedge clk);
			rbv <= 1'b1;
			rbz <= z;
		end
		@(posedge clk);
		rbv <= 1'b0;
	endtask
	task automatic bpvs(input int k, input logic s);
		repeat (k) begin
			@(posedge clk);
			bpv <= 1'b1;
			sub <= s;
		end
		@(posedge clk);
		bpv <= 1'b0;
	endtask
	task automatic ev(input int k);
		repeat (k) begin
			@(posedge clk);
			pe <= 1'b1;
			mos <= 1'b1;
		end
		@(posedge clk);
		pe <= 1'b0;
		mos <= 1'b0;
	endtask
	task automatic dl_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			dlv <= 1'b1;
			dlb <= b[i];
		end
		@(posedge clk);
		dlv <= 1'b0;
	endtask
	task automatic sig(input logic [23:0] v);
		@(posedge clk);
		sigv <= 1'b1;
		sigb <= v;
		@(posedge clk);
		sigv <= 1'b0;
	endtask
	// Snapshots only move on interval boundaries, so polling is bounded.
	task automatic poll_cv(input logic eq);
		int k;
		k = 0;
		rd(fsi_pkg::IDX_CV_LOW);
		while ((rdv === 32'h1) != eq) begin
			k++;
			if (k > 500) hang();
			rd(fsi_pkg::IDX_CV_LOW);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(fsi_pkg::IDX_ENABLE_ONE);
		chk("enable one reset", rdv, 32'h0);
		rd(fsi_pkg::IDX_ENABLE_TWO);
		chk("enable two reset", rdv, 32'h0);
		wr(fsi_pkg::IDX_ENABLE_ONE, 8'ha5);
		rd(fsi_pkg::IDX_ENABLE_ONE);
		chk("enable one", rdv, 32'ha5);
		fsi_host_model_i.xfer(1'b0, 12'h0fc, 8'h0, rdv, rr);
		chk("unmapped resp", rr, fsi_pkg::RESP_SLVERR);
		fsi_host_model_i.xfer(1'b0, 12'hc84, 8'h0, rdv, rr);
		chk("outside resp", rr, fsi_pkg::RESP_SLVERR);
		$display("test 1 done");
		wr(fsi_pkg::IDX_MATCH_A, 8'h5a);
		dl_byte(8'h5a);
		@(posedge clk);
		txe <= 1'b1;
		mf <= 1'b1;
		@(posedge clk);
		txe <= 1'b0;
		mf <= 1'b0;
		sig(24'h1);
		sig(24'h3);
		rd(fsi_pkg::IDX_STATUS_TWO);
		chk("status two", rdv, 32'hdd);
		rd(fsi_pkg::IDX_STATUS_TWO);
		chk("status two cleared", rdv, 32'h0);
		dl_byte(8'hff);
		rd(fsi_pkg::IDX_STATUS_TWO);
		chk("status two abort", rdv, 32'h12);
		wr(fsi_pkg::IDX_MATCH_B, 8'hc3);
		dl_byte(8'hc3);
		rd(fsi_pkg::IDX_STATUS_TWO);
		chk("status two match b", rdv, 32'h14);
		wr(fsi_pkg::IDX_ENABLE_ONE, 8'h00);
		wr(fsi_pkg::IDX_ENABLE_TWO, 8'h01);
		@(posedge clk);
		txe <= 1'b1;
		@(posedge clk);
		txe <= 1'b0;
		#1 chk("irq masked", irq, 1'b0);
		sig(24'h0);
		#1 chk("irq enabled", irq, 1'b1);
		rd(fsi_pkg::IDX_STATUS_TWO);
		#1 chk("irq cleared", irq, 1'b0);
		@(posedge clk);
		al.sync_loss <= 1'b1;
		wr(fsi_pkg::IDX_ENABLE_ONE, 8'h01);
		#1 chk("irq alarm", irq, 1'b1);
		@(posedge clk);
		al.sync_loss <= 1'b0;
		rd(fsi_pkg::IDX_STATUS_ONE);
		chk("status one", rdv[0], 1'b1);
		wr(fsi_pkg::IDX_ENABLE_ONE, 8'h00);
		$display("test 2 done");
		for (int c = 0; c < 2; c++) begin
			wr(fsi_pkg::IDX_CONTROL, cctl[c]);
			bpvs(1, 1'b0);
			poll_cv(1'b1);
			ev(2);
			@(posedge clk);
			al.sync_loss <= 1'b1;
			ev(1);
			bpvs(cb[c], 1'b0);
			bpvs(cs[c], 1'b1);
			bits(cz[c], 1'b1);
			@(posedge clk);
			al.sync_loss <= 1'b0;
			poll_cv(1'b0);
			chk("count low", rdv, ce[c]);
			rd(fsi_pkg::IDX_CV_HIGH);
			chk("count high", rdv, 32'h0);
			rd(fsi_pkg::IDX_PATH_LOW);
			chk("path count", rdv, 32'h2);
			rd(fsi_pkg::IDX_MOS_LOW);
			chk("out of sync count", rdv, 32'h3);
		end
		$display("test 3 done");
		wr(fsi_pkg::IDX_CONTROL, 8'h00);
		// Sixty cycles always hold one whole blue window of the new level.
		@(posedge clk);
		rbv <= 1'b1;
		rbz <= 1'b1;
		repeat (60) @(posedge clk);
		rd(fsi_pkg::IDX_STATUS_ONE);
		rd(fsi_pkg::IDX_STATUS_ONE);
		chk("blue off", rdv[3], 1'b0);
		rbv <= 1'b0;
		repeat (60) @(posedge clk);
		rd(fsi_pkg::IDX_STATUS_ONE);
		rd(fsi_pkg::IDX_STATUS_ONE);
		chk("blue on", {rdv[3], rdv[0]}, 2'h2);
		wr(fsi_pkg::IDX_ENABLE_TWO, 8'h20);
		rd(fsi_pkg::IDX_STATUS_TWO);
		for (int k = 0; k < 4; k++) begin
			n = 0;
			while (irq !== 1'b1) begin
				@(posedge clk);
				n++;
				if (n > 9000) hang();
			end
			t[k] = cyc;
			rd(fsi_pkg::IDX_STATUS_TWO);
		end
		n = 0;
		for (int k = 1; k < 4; k++) n += (t[k] - t[k - 1] > 1001 * TICK_MS);
		chk("long seconds", n, 1);
		chk("three seconds", (t[3] - t[0] + 4) / TICK_MS, 3000);
		$display("test 4 done");
		give_verdict();
	end
endmodule // tb
